// ### tape_fmt_params.svh
// Register offsets, field positions, codes and timing counts of the tape formatter
`ifndef TAPE_FMT_PARAMS_SVH
`define TAPE_FMT_PARAMS_SVH

// Register word offsets
`define REG_CONNECT        3'h0
`define REG_FUNCTION       3'h1
`define REG_FORMAT         3'h2
`define REG_STATUS         3'h3
`define REG_DATA           3'h4
`define REG_INT_STAT       3'h5
`define REG_INT_MASK       3'h6

// Function codes written to the function register
`define FN_WRITE           3'h1
`define FN_READ            3'h2
`define FN_FILE_MARK       3'h3
`define FN_RELEASE         3'h4

// Format register fields and reset value
`define FMT_BINARY_BIT     0
`define FMT_CHAR_BIT       1
`define FMT_DENS_LSB       2
`define FMT_DENS_MSB       3
`define FMT_RESET          4'h1
`define DENS_200           2'h0
`define DENS_556           2'h1
`define DENS_800           2'h2

// Connect register reset value
`define UNIT_RESET         3'h0

// Status register bits
`define ST_BUSY            0
`define ST_CONNECTED       1
`define ST_EOR             2
`define ST_EOP             3
`define ST_RING            4
`define ST_IN_FULL         5
`define ST_OUT_FULL        6
`define ST_WRITING         7

// Interrupt status and mask bits
`define EV_EOR             0
`define EV_EOP             1
`define EV_FRAME_PAR       2
`define EV_CHECK_CHAR      3
`define EV_DONE            4
`define EV_REFUSED         5
`define EV_W               6

// Recording constants
`define FILE_MARK_CHAR     6'h0F
`define CC_GAP_FRAMES      2'h3

// Timing
`define CLK_PERIOD_NS      100
`define TAPE_IPS           75
`define FRAME_NS(cpi)      (1000000000 / (`TAPE_IPS * (cpi)))
`define FRAME_CYC(cpi)     (`FRAME_NS(cpi) / `CLK_PERIOD_NS)
`define STOP_TIME_US       2000
`define STOP_CYC           ((`STOP_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FM_GAP_IN          6
`define FM_GAP_US          (`FM_GAP_IN * 1000000 / `TAPE_IPS)
`define FM_GAP_CYC         ((`FM_GAP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### tape_fmt_pkg.sv
// Types shared by the tape formatter
package tape_fmt_pkg;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_WR_DATA  = 4'h1,
    S_WR_CCGAP = 4'h2,
    S_WR_CHECK = 4'h3,
    S_FM_GAP   = 4'h4,
    S_FM_CHAR  = 4'h5,
    S_RD_DATA  = 4'h6,
    S_STOPPING = 4'h7
  } state_e;

  typedef logic [1:0] density_t;

endpackage

// ### frame_parity.sv
// Transverse parity bit of one tape frame
`timescale 1ns/10ps
module frame_parity #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] data_in,  // Frame character bits
  input  wire logic         odd_in,   // High for odd parity
  output logic              par_out   // Parity bit to record or expect
);
  assign par_out = (^data_in) ^ odd_in;
endmodule

// ### tape_record_formatter.sv
// Tape record formatter: selection, disassembly, assembly and parity
//
// How it works
// R1: Output words split into 6-bit characters, one tape frame each.
// R2: Exactly three blank frames precede each record's check character.
// R3: File mark is one even-parity octal 17 frame plus its check.
// R4: Six inches of blank tape precede the file mark.
// R5: Reading checks frame parity and the longitudinal check character.
// R6: A blank gap after data frames on read gives end of record.
// R7: Input request after end of record gives end of operation.
// R8: While busy, new function codes and selection writes are ignored.
// R9: Assembled input words wait in a holding register until read.
// R10: No writing unless the write-permit ring is present.
// R11: Connect only succeeds when the address matches the unit switch.
// R12: Connect selects this controller and its handler for later functions.
// R13: Format picks parity, assembly mode and 200/556/800 density.
// R14: Handler needs 2 ms stop time before motion counts as ended.
// R15: Binary format uses odd frame parity, coded format even.
// R16: Check character makes each of the six data tracks' count of ones even.
// R17: Read characters are packed into computer words.
`timescale 1ns/10ps
`include "tape_fmt_params.svh"
module tape_record_formatter
  import tape_fmt_pkg::*;
#(
  parameter int WORD_W   = 12,
  parameter int STOP_CYC = `STOP_CYC,
  parameter int GAP_CYC  = `FM_GAP_CYC
) (
  input  wire logic        REF_CLK_IN,        // System clock, 10 MHz
  input  wire logic        ARST_N_IN,         // Async reset, active low
  input  wire logic [2:0]  ADDR_IN,           // Register word address
  input  wire logic [15:0] WDATA_IN,          // Register write data
  input  wire logic        WR_EN_IN,          // Write strobe
  input  wire logic        RD_EN_IN,          // Read strobe
  output logic      [15:0] RDATA_OUT,         // Read data, next cycle
  output logic             IRQ_OUT,           // Interrupt level
  input  wire logic [6:0]  TAPE_RD_DATA_IN,   // Read frame, bit 6 parity
  input  wire logic        TAPE_RD_STROBE_IN, // Read frame strobe
  input  wire logic        TAPE_GAP_IN,       // Record gap sensed
  input  wire logic        WRITE_RING_IN,     // Write-permit ring present
  input  wire logic [2:0]  UNIT_SWITCH_IN,    // Equipment select switch
  output logic      [6:0]  TAPE_WR_DATA_OUT,  // Write frame, bit 6 parity
  output logic             TAPE_WR_STROBE_OUT,// Write frame pulse
  output logic             TAPE_MOTION_OUT,   // Tape motion request
  output logic             TAPE_WRITE_OUT,    // Write current enable
  output logic             UNIT_SELECT_OUT,   // Handler selected
  output density_t         DENSITY_OUT        // Recording density code
);

  localparam int CHARS = WORD_W / 6;
  localparam int CW    = $clog2(CHARS + 1);
  localparam int SYN_W = 13;
  localparam logic [23:0] GAP_L  = 24'(GAP_CYC);
  localparam logic [23:0] STOP_L = 24'(STOP_CYC);

  state_e            state_r;
  logic [SYN_W-1:0]  meta_r;
  logic [SYN_W-1:0]  sync_r;
  logic [6:0]        rd_data_s;
  logic              strobe_s;
  logic              gap_s;
  logic              ring_s;
  logic [2:0]        sw_s;
  logic              strobe_d_r;
  logic              gap_d_r;
  logic              connected_r;
  logic [2:0]        unit_r;
  logic [3:0]        fmt_r;
  logic [`EV_W-1:0]  mask_r;
  logic [`EV_W-1:0]  int_r;
  logic [`EV_W-1:0]  ev;
  logic [WORD_W-1:0] out_word_r;
  logic              out_full_r;
  logic [WORD_W-1:0] sh_r;
  logic [CW-1:0]     chars_r;
  logic [1:0]        gap_cnt_r;
  logic [5:0]        lrc_r;
  logic              fm_r;
  logic [6:0]        wr_frame_r;
  logic              wr_strobe_r;
  logic              motion_r;
  logic              write_en_r;
  logic [23:0]       tmr_r;
  logic [23:0]       lim;
  logic              tick;
  logic              emit;
  logic [5:0]        emit_char;
  logic              emit_par;
  logic              par_odd;
  logic [5:0]        rd_lrc_r;
  logic [5:0]        pend_r;
  logic              pend_v_r;
  logic              seen_r;
  logic [WORD_W-1:0] asm_r;
  logic [CW-1:0]     asm_cnt_r;
  logic [WORD_W-1:0] push_word;
  logic              push;
  logic [WORD_W-1:0] in_word_r;
  logic              in_full_r;
  logic              eor_r;
  logic              eop_r;
  logic              rd_par;
  logic [15:0]       status;
  logic [15:0]       rdata_r;
  logic              idle;
  logic              char_mode;
  logic              fn_go;
  logic              start_wr;
  logic              start_rd;
  logic              start_fm;
  logic              refuse;
  logic              wr_connect;
  logic              wr_format;
  logic              wr_data;
  logic              rd_data_req;
  logic              load_word;
  logic              rd_frame;
  logic              gap_ev;
  logic              perr_ev;

  // Two-stage synchroniser for every handler pin
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {TAPE_RD_DATA_IN, TAPE_RD_STROBE_IN, TAPE_GAP_IN,
                 WRITE_RING_IN, UNIT_SWITCH_IN};
      sync_r <= meta_r;
    end
  end

  assign rd_data_s = sync_r[12:6];
  assign strobe_s  = sync_r[5];
  assign gap_s     = sync_r[4];
  assign ring_s    = sync_r[3];
  assign sw_s      = sync_r[2:0];

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      strobe_d_r <= 1'b0;
      gap_d_r    <= 1'b0;
    end else begin
      strobe_d_r <= strobe_s;
      gap_d_r    <= gap_s;
    end
  end

  // Bus decode and function start
  assign idle        = (state_r == S_IDLE);
  assign char_mode   = fmt_r[`FMT_CHAR_BIT];
  assign wr_connect  = WR_EN_IN && (ADDR_IN == `REG_CONNECT) && idle; // [R8]
  assign wr_format   = WR_EN_IN && (ADDR_IN == `REG_FORMAT) && idle;  // [R8]
  assign wr_data     = WR_EN_IN && (ADDR_IN == `REG_DATA);
  assign rd_data_req = RD_EN_IN && (ADDR_IN == `REG_DATA);
  assign fn_go       = WR_EN_IN && (ADDR_IN == `REG_FUNCTION) && idle &&
                       connected_r;                                  // [R8] [R12]
  assign start_wr = fn_go && (WDATA_IN[2:0] == `FN_WRITE) && ring_s;  // [R10]
  assign start_fm = fn_go && (WDATA_IN[2:0] == `FN_FILE_MARK) && ring_s;
  assign start_rd = fn_go && (WDATA_IN[2:0] == `FN_READ);
  assign refuse   = fn_go && !ring_s &&
                    ((WDATA_IN[2:0] == `FN_WRITE) ||
                     (WDATA_IN[2:0] == `FN_FILE_MARK));              // [R10]

  // Selection of controller and handler
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      unit_r      <= `UNIT_RESET;
      connected_r <= 1'b0;
    end else if (wr_connect) begin
      unit_r      <= WDATA_IN[2:0];
      connected_r <= (WDATA_IN[2:0] == sw_s);                        // [R11] [R12]
    end else if (fn_go && (WDATA_IN[2:0] == `FN_RELEASE)) begin
      connected_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fmt_r  <= `FMT_RESET;
      mask_r <= '0;
    end else begin
      if (wr_format) begin
        fmt_r <= WDATA_IN[3:0];                                      // [R13]
      end
      if (WR_EN_IN && (ADDR_IN == `REG_INT_MASK)) begin
        mask_r <= WDATA_IN[`EV_W-1:0];
      end
    end
  end

  // Frame period by density; gap and stop times
  always_comb begin
    case (state_r)
      S_FM_GAP:   lim = GAP_L;                                       // [R4]
      S_STOPPING: lim = STOP_L;                                      // [R14]
      default: begin
        case (fmt_r[`FMT_DENS_MSB:`FMT_DENS_LSB])                    // [R13]
          `DENS_556: lim = 24'(`FRAME_CYC(556));
          `DENS_800: lim = 24'(`FRAME_CYC(800));
          default:   lim = 24'(`FRAME_CYC(200));
        endcase
      end
    endcase
  end

  assign tick = (tmr_r == lim - 24'h1);

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tmr_r <= '0;
    end else if (idle || (state_r == S_RD_DATA) || tick) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + 24'h1;
    end
  end

  // Output word waiting for disassembly
  assign load_word = (state_r == S_WR_DATA) && tick && (chars_r == '0) &&
                     out_full_r;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      out_word_r <= '0;
      out_full_r <= 1'b0;
    end else if (wr_data && (!out_full_r || load_word)) begin
      out_word_r <= WDATA_IN[WORD_W-1:0];
      out_full_r <= 1'b1;
    end else if (load_word) begin
      out_full_r <= 1'b0;
    end
  end

  // Character to be written in this frame time
  always_comb begin
    emit      = 1'b0;
    emit_char = 6'h00;
    case (state_r)
      S_WR_DATA: begin
        if (tick && (chars_r != '0)) begin
          emit      = 1'b1;
          emit_char = sh_r[WORD_W-1 -: 6];                           // [R1]
        end else if (load_word) begin
          emit      = 1'b1;
          emit_char = char_mode ? out_word_r[5:0] :
                                  out_word_r[WORD_W-1 -: 6];         // [R1]
        end
      end
      S_WR_CHECK: begin
        emit      = tick;
        emit_char = lrc_r;                                           // [R16]
      end
      S_FM_CHAR: begin
        emit      = tick;
        emit_char = `FILE_MARK_CHAR;                                 // [R3]
      end
      default: begin
        emit      = 1'b0;
        emit_char = 6'h00;
      end
    endcase
  end

  assign par_odd = fmt_r[`FMT_BINARY_BIT] && !fm_r;                  // [R15] [R3]

  frame_parity #(.W(6)) u_wr_par (
    .data_in (emit_char),
    .odd_in  (par_odd),
    .par_out (emit_par)
  );

  // Sequencer for write, file mark, read and stop
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_r     <= S_IDLE;
      sh_r        <= '0;
      chars_r     <= '0;
      gap_cnt_r   <= 2'h0;
      lrc_r       <= 6'h00;
      fm_r        <= 1'b0;
      wr_frame_r  <= 7'h00;
      wr_strobe_r <= 1'b0;
      motion_r    <= 1'b0;
      write_en_r  <= 1'b0;
    end else begin
      wr_strobe_r <= emit;
      if (emit) begin
        wr_frame_r <= {emit_par, emit_char};
      end
      if (emit && (state_r != S_WR_CHECK)) begin
        lrc_r <= lrc_r ^ emit_char;                                  // [R16]
      end
      case (state_r)
        S_IDLE: begin
          lrc_r   <= 6'h00;
          chars_r <= '0;
          if (start_wr) begin
            state_r    <= S_WR_DATA;
            motion_r   <= 1'b1;
            write_en_r <= 1'b1;                                      // [R10]
            fm_r       <= 1'b0;
          end else if (start_fm) begin
            state_r    <= S_FM_GAP;
            motion_r   <= 1'b1;
            write_en_r <= 1'b1;                                      // [R10]
            fm_r       <= 1'b1;
          end else if (start_rd) begin
            state_r  <= S_RD_DATA;
            motion_r <= 1'b1;
          end
        end
        S_WR_DATA: begin
          if (tick && (chars_r != '0)) begin
            sh_r    <= {sh_r[WORD_W-7:0], 6'h00};                    // [R1]
            chars_r <= chars_r - CW'(1);
          end else if (load_word) begin
            sh_r    <= {out_word_r[WORD_W-7:0], 6'h00};
            chars_r <= char_mode ? '0 : CW'(CHARS - 1);
          end else if (tick) begin
            state_r   <= S_WR_CCGAP;
            gap_cnt_r <= 2'h1;                                       // [R2]
          end
        end
        S_WR_CCGAP: begin
          if (tick) begin
            if (gap_cnt_r == `CC_GAP_FRAMES - 2'h1) begin
              state_r <= S_WR_CHECK;                                 // [R2]
            end else begin
              gap_cnt_r <= gap_cnt_r + 2'h1;
            end
          end
        end
        S_WR_CHECK: begin
          if (tick) begin
            state_r    <= S_STOPPING;
            motion_r   <= 1'b0;
            write_en_r <= 1'b0;
          end
        end
        S_FM_GAP: begin
          if (tick) begin
            state_r <= S_FM_CHAR;                                    // [R4]
          end
        end
        S_FM_CHAR: begin
          if (tick) begin
            state_r   <= S_WR_CCGAP;
            gap_cnt_r <= 2'h0;
          end
        end
        S_RD_DATA: begin
          if (gap_ev) begin
            state_r  <= S_STOPPING;                                  // [R6]
            motion_r <= 1'b0;
          end
        end
        S_STOPPING: begin
          if (tick) begin
            state_r <= S_IDLE;                                       // [R14]
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Read path: the last frame before the gap is the check character
  assign rd_frame = strobe_s && !strobe_d_r && (state_r == S_RD_DATA);
  assign gap_ev   = gap_s && !gap_d_r && (state_r == S_RD_DATA) && seen_r;

  frame_parity #(.W(6)) u_rd_par (
    .data_in (rd_data_s[5:0]),
    .odd_in  (fmt_r[`FMT_BINARY_BIT]),
    .par_out (rd_par)
  );

  assign perr_ev   = rd_frame && (rd_par != rd_data_s[6]);           // [R5] [R15]
  assign push      = rd_frame && pend_v_r &&
                     (char_mode || (asm_cnt_r == CW'(CHARS - 1)));
  assign push_word = char_mode ? {{(WORD_W-6){1'b0}}, pend_r} :
                                 {asm_r[WORD_W-7:0], pend_r};        // [R17]

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_lrc_r  <= 6'h00;
      pend_r    <= 6'h00;
      pend_v_r  <= 1'b0;
      seen_r    <= 1'b0;
      asm_r     <= '0;
      asm_cnt_r <= '0;
    end else if (start_rd) begin
      rd_lrc_r  <= 6'h00;
      pend_v_r  <= 1'b0;
      seen_r    <= 1'b0;
      asm_cnt_r <= '0;
    end else if (rd_frame) begin
      rd_lrc_r <= rd_lrc_r ^ rd_data_s[5:0];                         // [R5]
      pend_r   <= rd_data_s[5:0];
      pend_v_r <= 1'b1;
      seen_r   <= 1'b1;
      if (pend_v_r && !char_mode) begin
        asm_r     <= {asm_r[WORD_W-7:0], pend_r};                    // [R17]
        asm_cnt_r <= push ? '0 : asm_cnt_r + CW'(1);
      end
    end
  end

  // Holding register between tape timing and computer timing
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      in_word_r <= '0;
      in_full_r <= 1'b0;
    end else if (push) begin
      in_word_r <= push_word;                                        // [R9]
      in_full_r <= 1'b1;
    end else if (rd_data_req) begin
      in_full_r <= 1'b0;                                             // [R9]
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      eor_r <= 1'b0;
      eop_r <= 1'b0;
    end else begin
      if (gap_ev) begin
        eor_r <= 1'b1;                                               // [R6]
      end else if (fn_go) begin
        eor_r <= 1'b0;
      end
      if (ev[`EV_EOP]) begin
        eop_r <= 1'b1;                                               // [R7]
      end else if (fn_go) begin
        eop_r <= 1'b0;
      end
    end
  end

  // Interrupt events, sticky until the interrupt status is read
  always_comb begin
    ev                 = '0;
    ev[`EV_EOR]        = gap_ev;
    ev[`EV_EOP]        = rd_data_req && !in_full_r && eor_r;         // [R7]
    ev[`EV_FRAME_PAR]  = perr_ev;
    ev[`EV_CHECK_CHAR] = gap_ev && (rd_lrc_r != 6'h00);              // [R5] [R16]
    ev[`EV_DONE]       = (state_r == S_STOPPING) && tick;
    ev[`EV_REFUSED]    = refuse;
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      int_r <= '0;
    end else if (RD_EN_IN && (ADDR_IN == `REG_INT_STAT)) begin
      int_r <= ev;
    end else begin
      int_r <= int_r | ev;
    end
  end

  always_comb begin
    status                = '0;
    status[`ST_BUSY]      = !idle;
    status[`ST_CONNECTED] = connected_r;
    status[`ST_EOR]       = eor_r;
    status[`ST_EOP]       = eop_r;
    status[`ST_RING]      = ring_s;
    status[`ST_IN_FULL]   = in_full_r;
    status[`ST_OUT_FULL]  = out_full_r;
    status[`ST_WRITING]   = write_en_r;
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_r <= 16'h0000;
    end else if (RD_EN_IN) begin
      case (ADDR_IN)
        `REG_CONNECT:  rdata_r <= {12'h000, connected_r, unit_r};
        `REG_FORMAT:   rdata_r <= {12'h000, fmt_r};
        `REG_STATUS:   rdata_r <= status;
        `REG_DATA:     rdata_r <= 16'(in_word_r);
        `REG_INT_STAT: rdata_r <= {{(16-`EV_W){1'b0}}, int_r};
        `REG_INT_MASK: rdata_r <= {{(16-`EV_W){1'b0}}, mask_r};
        default:       rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign RDATA_OUT          = rdata_r;
  assign IRQ_OUT            = |(int_r & mask_r);
  assign TAPE_WR_DATA_OUT   = wr_frame_r;
  assign TAPE_WR_STROBE_OUT = wr_strobe_r;
  assign TAPE_MOTION_OUT    = motion_r;
  assign TAPE_WRITE_OUT     = write_en_r;
  assign UNIT_SELECT_OUT    = connected_r;
  assign DENSITY_OUT        = fmt_r[`FMT_DENS_MSB:`FMT_DENS_LSB];

  default clocking dflt_cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  a_ring_inhibit: assert property (refuse |=> idle && !write_en_r) // [R10]
    else $error("write started without ring");
  a_ccgap_blank: assert property (                                // [R2]
    (state_r == S_WR_CCGAP) && ($past(state_r) == S_WR_CCGAP)
      |-> !wr_strobe_r)
    else $error("frame written in check gap");
  a_ccgap_count: assert property (                                // [R2]
    $rose(state_r == S_WR_CHECK) |-> $past(gap_cnt_r) == 2'h2)
    else $error("check gap not three frames");
  a_file_mark: assert property (                                  // [R3]
    (state_r == S_FM_CHAR) && tick
      |=> wr_strobe_r && (wr_frame_r == 7'h0F))
    else $error("file mark frame wrong");
  a_fm_gap_blank: assert property (                               // [R4]
    (state_r == S_FM_GAP) && ($past(state_r) == S_FM_GAP)
      |-> !wr_strobe_r && motion_r)
    else $error("frame inside file mark gap");
  a_lockout_fmt: assert property (                                // [R8]
    !idle && WR_EN_IN && (ADDR_IN == `REG_FORMAT)
      |=> $stable(fmt_r))
    else $error("format changed while busy");
  a_select_match: assert property (                               // [R11]
    wr_connect |=> connected_r == ($past(WDATA_IN[2:0]) == $past(sw_s)))
    else $error("connect ignores unit switch");
  a_frame_parity: assert property (                               // [R15]
    wr_strobe_r |-> (^wr_frame_r) == (fmt_r[`FMT_BINARY_BIT] && !fm_r))
    else $error("write frame parity wrong");
  a_eor_gap: assert property (gap_ev |=> (state_r == S_STOPPING) && eor_r) // [R6]
    else $error("end of record missed");
  a_eop_flag: assert property (ev[`EV_EOP] |=> eop_r && int_r[`EV_EOP]) // [R7]
    else $error("end of operation missed");
  a_hold_word: assert property (in_full_r && !rd_data_req && !push
      |=> in_full_r && $stable(in_word_r))                        // [R9]
    else $error("holding register lost word");

endmodule

// ### tape_handler_model.sv
// Tape handler model: ring, read frames and gap
`timescale 1ns/10ps
module tape_handler_model (
  input  wire logic       clk_in,   // Clock
  input  wire logic       ring_in,  // Ring fitted
  output logic            ring_out, // Write-permit ring
  output logic [6:0]      rd_out,   // Read frame
  output logic            stb_out,  // Read strobe
  output logic            gap_out   // Gap sensed
);
  assign ring_out = ring_in;
  initial begin
    rd_out = 7'h2A;
    stb_out = 1'b0;
    gap_out = 1'b0;
  end
  task automatic send(input logic [6:0] f);
    @(posedge clk_in) rd_out <= f;
    repeat (3) @(posedge clk_in);
    stb_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    stb_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd_out <= ~f;  // Stale data never left valid
  endtask
  task automatic gap();
    @(posedge clk_in) gap_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    gap_out <= 1'b0;
  endtask
endmodule

// ### tape_record_formatter_test.sv
// Self-checking bench of the tape record formatter
`timescale 1ns/10ps
`include "tape_fmt_params.svh"
module tape_record_formatter_test;
  import tape_fmt_pkg::*;
  localparam int STOP = 20;
  localparam int F = `FRAME_CYC(800);
  logic clk, rst_n, we, re, ring, rd_d, stb, gap, rg, irq, wstb, mot, wen, sel;
  logic [2:0]  addr, sw;
  logic [15:0] wd, rdata;
  logic [6:0]  rdf, wf;
  density_t    dens;
  logic [31:0] rq[$], fq[$], x;
  int          n_mismatch, n_checks, cyc, last;
  logic [11:0] w;
  logic [5:0]  hi, lo;
  tape_record_formatter #(.STOP_CYC(STOP), .GAP_CYC(50)) dut (
    .REF_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_EN_IN(we), .RD_EN_IN(re), .RDATA_OUT(rdata), .IRQ_OUT(irq),
    .TAPE_RD_DATA_IN(rdf), .TAPE_RD_STROBE_IN(stb), .TAPE_GAP_IN(gap),
    .WRITE_RING_IN(rg), .UNIT_SWITCH_IN(sw), .TAPE_WR_DATA_OUT(wf),
    .TAPE_WR_STROBE_OUT(wstb), .TAPE_MOTION_OUT(mot),
    .TAPE_WRITE_OUT(wen), .UNIT_SELECT_OUT(sel), .DENSITY_OUT(dens));
  tape_handler_model hm (.clk_in(clk), .ring_in(ring), .ring_out(rg),
    .rd_out(rdf), .stb_out(stb), .gap_out(gap));
  function automatic logic [6:0] fr(input logic [5:0] c, input logic odd);
    return {odd ? ~^c : ^c, c};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e, m);
    rq.push_back({m, e});
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
  endtask
  task automatic fin();
    wait (fq.size() == 0);
    repeat (STOP + 10) @(posedge clk);
  endtask
  task automatic rec(input logic [5:0] h, l, input logic p, input logic [5:0] d);
    wr(`REG_FUNCTION, `FN_READ);
    hm.send(fr(h, p));
    hm.send(fr(l, 1'b1));
    hm.send(fr(h ^ l ^ d, 1'b1));
    hm.gap();
    repeat (STOP + 10) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    rd_d <= re;
    if (rd_d) begin
      x = rq.pop_front();
      chk(rdata & x[31:16], x[15:0] & x[31:16]);
    end
    if (wstb) begin
      x = fq.pop_front();
      if (x[31:7] != 0) chk(cyc - last, x[31:7]);
      chk(wf, x[6:0]);
      last = cyc;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {rst_n, we, re, ring, addr, wd} = '0;
    {n_mismatch, n_checks, cyc, last} = '0;
    void'($urandom(66));
    sw <= 3'($urandom);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`REG_FORMAT, 16'h0001, 16'hFFFF);
    rd(3'h7, 16'h0000, 16'hFFFF);
    wr(`REG_CONNECT, {13'h0, ~sw});
    rd(`REG_CONNECT, {13'h0, ~sw}, 16'hFFFF);
    wr(`REG_CONNECT, {13'h0, sw});
    rd(`REG_CONNECT, {13'h1, sw}, 16'hFFFF);
    chk(sel, 1);
    wr(`REG_FUNCTION, `FN_WRITE);
    rd(`REG_INT_STAT, 16'h0020, 16'hFFFF);
    chk(wen, 0);
    wr(`REG_FORMAT, 16'h0009);
    wr(`REG_INT_MASK, 16'h0010);
    chk(dens, `DENS_800);
    ring <= 1'b1;
    w = 12'($urandom);
    hi = w[11:6];
    lo = w[5:0];
    repeat (3) @(posedge clk);
    fq.push_back({25'h0, fr(hi, 1'b1)});
    fq.push_back({25'(F), fr(lo, 1'b1)});
    fq.push_back({25'(4 * F), fr(hi ^ lo, 1'b1)});
    wr(`REG_FUNCTION, `FN_WRITE);
    wr(`REG_DATA, {4'h0, w});
    chk({mot, wen}, 2'h3);
    wr(`REG_CONNECT, {13'h0, ~sw});
    wr(`REG_FORMAT, 16'h0000);
    rd(`REG_CONNECT, {13'h1, sw}, 16'hFFFF);
    rd(`REG_FORMAT, 16'h0009, 16'hFFFF);
    rd(`REG_STATUS, 16'h00D3, 16'hFFFF);
    fin();
    chk({mot, wen}, 2'h0);
    chk(irq, 1);
    rd(`REG_INT_STAT, 16'h0010, 16'hFFFF);
    @(posedge clk) chk(irq, 0);
    fq.push_back({25'h0, 7'h0F});
    fq.push_back({25'(4 * F), 7'h0F});
    wr(`REG_FUNCTION, `FN_FILE_MARK);
    fin();
    rec(hi, lo, 1'b1, 6'h00);
    rd(`REG_DATA, {4'h0, w}, 16'hFFFF);
    rd(`REG_INT_STAT, 16'h0001, 16'h000F);
    rd(`REG_DATA, 16'h0000, 16'h0000);
    rd(`REG_INT_STAT, 16'h0002, 16'h0002);
    rec(hi, lo, 1'b0, 6'h01);
    rd(`REG_INT_STAT, 16'h000D, 16'h000D);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
